// ==== src/wakeup_seq_map.svh ====
/*
  Offsets, field positions, reset values and timing counts of the
  low-power wake-up warm-up sequencer.
  Assumes inclusion by its bare name from the sequencer module and the bench.
*/
`ifndef WAKEUP_SEQ_MAP_SVH
`define WAKEUP_SEQ_MAP_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFF_OSC_CTRL 12'h000
`define OFF_MULT_SEL 12'h004
`define OFF_SYS_CTRL 12'h008
`define OFF_STANDBY_MODE_FIELD_CTRL 12'h00C
`define OFF_STATUS 12'h010
`define OFF_WAKE_CMD 12'h014

// ************************************************************
// oscillator_control_reg fields
// ************************************************************
`define OSC_WARMUP_TIME_VALUE_LSB 20
`define OSC_WARMUP_TIME_VALUE_MSB 31
`define OSC_WSEL_HI_BIT 15
`define OSC_WSEL_LO_BIT 14
`define OSC_SEL_BIT 8
`define OSC_XEN_LO_BIT 1
`define OSC_XEN_HI_BIT 0

// multiplier_select_reg fields
`define MUL_SEL_BIT 0
`define MUL_ON_BIT 1

// standby_control_reg fields
`define STANDBY_MODE_FIELD_LSB 0
`define STANDBY_MODE_FIELD_MSB 2
`define STANDBY_MODE_FIELD_HOLD_BIT 16

// wake command bits (write one)
`define CMD_WFI_BIT 0

// ************************************************************
// reset values
// ************************************************************
`define RST_WARMUP_TIME_VALUE 12'h000
`define RST_WSEL_HI 1'b0
`define RST_WSEL_LO 1'b0
`define RST_OSC_SEL 1'b0
`define RST_XEN_LO 1'b0
`define RST_XEN_HI 1'b0
`define RST_MUL_SEL 1'b0
`define RST_MUL_ON 1'b0
`define RST_CLOCK_DIVIDER_A 3'h0
`define RST_STANDBY_MODE_FIELD 3'h3

// standby field codes
`define STANDBY_MODE_FIELD_DEEP 3'h1
`define STANDBY_MODE_FIELD_IDLE 3'h3
`define STANDBY_MODE_FIELD_GATED 3'h5

// ************************************************************
// timing
// ************************************************************
`define CLK_MHZ 50
`define PERIPH_RST_NS 100
`define PERIPH_RST_CYC ((`PERIPH_RST_NS * `CLK_MHZ + 999) / 1000)

`endif

// ==== src/wakeup_seq_pkg.sv ====
/*
  Types of the low-power wake-up warm-up sequencer.
  Assumes the map header is on the include path.
*/
package wakeup_seq_pkg;

  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_IDLE,
    ST_DEEP,
    ST_GATED,
    ST_WARMUP,
    ST_PRST
  } pmode_t;

  typedef struct packed {
    logic [11:0] warmup_time_value;
    logic wsel_hi;
    logic wsel_lo;
    logic osc_sel;
    logic xen_lo;
    logic xen_hi;
    logic mul_sel;
    logic mul_on;
    logic [2:0] clock_divider_a;
    logic [2:0] standby_mode_field;
    logic hold;
  } clk_cfg_t;

  typedef struct packed {
    logic aw_done;
    logic [11:0] aw_addr;
    logic w_done;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bus_st_t;

  typedef struct packed {
    pmode_t mode;
    logic [11:0] cnt;
    logic [3:0] prst_cnt;
    logic was_gated;
    logic aborted;
    logic sysclk_en;
    logic osc_on;
    logic periph_rst;
    logic core_run;
    logic vec_reset;
    logic irq_s1;
    logic irq_s2;
    clk_cfg_t cfg;
    bus_st_t bus;
  } state_t;

endpackage

// ==== src/wakeup_seq.sv ====
/*
  Low-power wake-up warm-up sequencer with an AXI4-Lite register slave.
  Assumes clk_i is the internal fast oscillator clock, rst_i covers every
  chip reset, and wake_req_i is asynchronous to clk_i.
*/
// Notes on behaviour
// RQ1: stop exit starts oscillator and warm-up timer
// RQ2: system clock held until warm-up elapses
// RQ3: real wake restores clock select bits
// RQ4: warm-up only on stop to normal
// RQ5: reset exit skips warm-up entirely
// RQ6: software sets three microseconds for deep-sleep
// RQ7: gated wake resets cut-off peripherals only
// RQ8: gated wake vectors core to reset handler
// RQ9: level wake held five hundred microseconds
// RQ10: software sets port hold before gated stop
// RQ11: pending wake request cancels mode entry
// RQ12: eight no-ops after masked wait
// RQ13: software matches warm-up and oscillator source
// RQ14: watchdog and detector stopped before stop
// RQ15: aborted gated entry keeps clock bits
// RQ16: software runs fast oscillator before gated
// RQ17: gated entry via wait, pending means skip
// RQ18: standby field selects entered mode
// RQ19: gated stop lasts forty-five microseconds minimum
// RQ20: timer counts from zero, clears in reset
`include "wakeup_seq_map.svh"
`timescale 1ns/1ps
`default_nettype none

module wakeup_seq
  import wakeup_seq_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // axi4-lite write address
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // wake source and core side
  input wire logic wake_req_i,
  output logic sysclk_en_o,
  output logic osc_on_o,
  output logic periph_rst_o,
  output logic core_run_o,
  output logic vec_reset_o,
  output logic port_state_hold_o,
  // clock configuration towards oscillator, multiplier and clock_divider_a
  output logic [11:0] warmup_time_value_o,
  output logic warmup_source_select_hi_o,
  output logic warmup_source_select_lo_o,
  output logic system_osc_select_o,
  output logic ext_low_osc_enable_o,
  output logic ext_high_osc_enable_o,
  output logic multiplier_clock_select_o,
  output logic multiplier_power_on_o,
  output logic [2:0] clock_divider_a_o
);

  state_t q;
  state_t d;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wake;
  logic [31:0] wmask;
  logic [31:0] osc_word;
  logic [31:0] mul_word;
  logic [31:0] sys_word;
  logic [31:0] standby_mode_field_word;
  logic [31:0] stat_word;
  logic [31:0] rd_word;
  logic rd_ok;
  // merged write word; kept apart from the read-side words so each has one driver
  logic [31:0] nw;

  assign aw_fire = s_axi_awvalid_i && !q.bus.aw_done && !q.bus.bvalid;
  assign w_fire = s_axi_wvalid_i && !q.bus.w_done && !q.bus.bvalid;
  assign ar_fire = s_axi_arvalid_i && !q.bus.rvalid;
  // only the second synchroniser stage is read
  assign wake = q.irq_s2;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{q.bus.w_strb[i]}};
    end
    osc_word = '0;
    osc_word[`OSC_WARMUP_TIME_VALUE_MSB:`OSC_WARMUP_TIME_VALUE_LSB] = q.cfg.warmup_time_value;
    osc_word[`OSC_WSEL_HI_BIT] = q.cfg.wsel_hi;
    osc_word[`OSC_WSEL_LO_BIT] = q.cfg.wsel_lo;
    osc_word[`OSC_SEL_BIT] = q.cfg.osc_sel;
    osc_word[`OSC_XEN_LO_BIT] = q.cfg.xen_lo;
    osc_word[`OSC_XEN_HI_BIT] = q.cfg.xen_hi;
    mul_word = '0;
    mul_word[`MUL_SEL_BIT] = q.cfg.mul_sel;
    mul_word[`MUL_ON_BIT] = q.cfg.mul_on;
    sys_word = {29'h0, q.cfg.clock_divider_a};
    standby_mode_field_word = '0;
    standby_mode_field_word[`STANDBY_MODE_FIELD_MSB:`STANDBY_MODE_FIELD_LSB] = q.cfg.standby_mode_field;
    standby_mode_field_word[`STANDBY_MODE_FIELD_HOLD_BIT] = q.cfg.hold;
    stat_word = {24'h0, q.aborted, q.was_gated, q.sysclk_en, 2'h0, q.mode};
  end

  always_comb begin
    d = q;
    nw = '0;
    // one maskable level input only: no watchdog or detector wake path
    d.irq_s1 = wake_req_i; // RQ14
    d.irq_s2 = q.irq_s1;
    // reset vector request is a single-cycle pulse
    d.vec_reset = 1'b0;

    // ************************************************************
    // register write channel
    // ************************************************************
    if (aw_fire) begin
      d.bus.aw_done = 1'b1;
      d.bus.aw_addr = s_axi_awaddr_i;
    end
    if (w_fire) begin
      d.bus.w_done = 1'b1;
      d.bus.w_data = s_axi_wdata_i;
      d.bus.w_strb = s_axi_wstrb_i;
    end
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      d.bus.bvalid = 1'b0;
    end
    if (q.bus.aw_done && q.bus.w_done) begin
      d.bus.aw_done = 1'b0;
      d.bus.w_done = 1'b0;
      d.bus.bvalid = 1'b1;
      d.bus.bresp = 2'h0;
      unique case ({q.bus.aw_addr[11:2], 2'h0})
        `OFF_OSC_CTRL: begin
          // byte lanes without strobe keep the stored field bits
          nw = (osc_word & ~wmask) | (q.bus.w_data & wmask);
          d.cfg.warmup_time_value = nw[`OSC_WARMUP_TIME_VALUE_MSB:`OSC_WARMUP_TIME_VALUE_LSB]; // RQ2
          d.cfg.wsel_hi = nw[`OSC_WSEL_HI_BIT];
          d.cfg.wsel_lo = nw[`OSC_WSEL_LO_BIT];
          d.cfg.osc_sel = nw[`OSC_SEL_BIT];
          d.cfg.xen_lo = nw[`OSC_XEN_LO_BIT];
          d.cfg.xen_hi = nw[`OSC_XEN_HI_BIT];
        end
        `OFF_MULT_SEL: begin
          nw = (mul_word & ~wmask) | (q.bus.w_data & wmask);
          d.cfg.mul_sel = nw[`MUL_SEL_BIT];
          d.cfg.mul_on = nw[`MUL_ON_BIT];
        end
        `OFF_SYS_CTRL: begin
          nw = (sys_word & ~wmask) | (q.bus.w_data & wmask);
          d.cfg.clock_divider_a = nw[2:0];
        end
        `OFF_STANDBY_MODE_FIELD_CTRL: begin
          nw = (standby_mode_field_word & ~wmask) | (q.bus.w_data & wmask);
          // codes other than the three modes are ignored, field keeps its value
          if (nw[`STANDBY_MODE_FIELD_MSB:`STANDBY_MODE_FIELD_LSB] == `STANDBY_MODE_FIELD_DEEP ||
              nw[`STANDBY_MODE_FIELD_MSB:`STANDBY_MODE_FIELD_LSB] == `STANDBY_MODE_FIELD_IDLE ||
              nw[`STANDBY_MODE_FIELD_MSB:`STANDBY_MODE_FIELD_LSB] == `STANDBY_MODE_FIELD_GATED) begin
            d.cfg.standby_mode_field = nw[`STANDBY_MODE_FIELD_MSB:`STANDBY_MODE_FIELD_LSB]; // RQ18
          end
          d.cfg.hold = nw[`STANDBY_MODE_FIELD_HOLD_BIT];
        end
        `OFF_WAKE_CMD: begin
          if (q.bus.w_strb[0] && q.bus.w_data[`CMD_WFI_BIT] && q.mode == ST_NORMAL) begin
            if (wake) begin
              // pending release request outranks the wait: stay in normal
              d.aborted = 1'b1; // RQ11 RQ17
            end else begin
              d.aborted = 1'b0;
              unique case (q.cfg.standby_mode_field)
                `STANDBY_MODE_FIELD_DEEP: d.mode = ST_DEEP; // RQ18
                `STANDBY_MODE_FIELD_GATED: d.mode = ST_GATED;
                default: d.mode = ST_IDLE;
              endcase
            end
            // clock bits untouched on abort
            // restore happens only on the warm-up path below, never here // RQ15
          end
        end
        `OFF_STATUS: d.bus.bresp = 2'h2;
        default: d.bus.bresp = 2'h2;
      endcase
    end

    // ************************************************************
    // register read channel
    // ************************************************************
    rd_ok = 1'b1;
    unique case ({s_axi_araddr_i[11:2], 2'h0})
      `OFF_OSC_CTRL: rd_word = osc_word;
      `OFF_MULT_SEL: rd_word = mul_word;
      `OFF_SYS_CTRL: rd_word = sys_word;
      `OFF_STANDBY_MODE_FIELD_CTRL: rd_word = standby_mode_field_word;
      `OFF_STATUS: rd_word = stat_word;
      `OFF_WAKE_CMD: rd_word = 32'h0;
      default: begin
        rd_word = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      d.bus.rvalid = 1'b0;
    end
    if (ar_fire) begin
      d.bus.rvalid = 1'b1;
      d.bus.rdata = rd_word;
      d.bus.rresp = rd_ok ? 2'h0 : 2'h2;
    end

    // ************************************************************
    // power mode sequencer
    // ************************************************************
    unique case (q.mode)
      ST_NORMAL: begin
        d.sysclk_en = 1'b1;
        d.osc_on = 1'b1;
        d.core_run = 1'b1;
      end
      ST_IDLE: begin
        // no warm-up into or out of idle
        d.core_run = 1'b0; // RQ4
        if (wake) begin
          d.mode = ST_NORMAL;
          d.core_run = 1'b1;
        end
      end
      ST_DEEP, ST_GATED: begin
        d.sysclk_en = 1'b0;
        d.osc_on = 1'b0;
        d.core_run = 1'b0;
        if (wake) begin
          d.osc_on = 1'b1; // RQ1
          d.cnt = 12'h000; // RQ20
          d.was_gated = (q.mode == ST_GATED);
          d.mode = ST_WARMUP; // RQ1 RQ4
        end
      end
      ST_WARMUP: begin
        // fast oscillator clocks the timer, no software step needed
        if (q.cnt >= q.cfg.warmup_time_value) begin
          d.sysclk_en = 1'b1; // RQ2 RQ20
        end else begin
          d.cnt = q.cnt + 12'h001; // RQ20
        end
        if (q.cnt >= q.cfg.warmup_time_value) begin
          // oscillator restarted, so selects return to initial values
          d.cfg.wsel_hi = `RST_WSEL_HI; // RQ3
          d.cfg.wsel_lo = `RST_WSEL_LO;
          d.cfg.osc_sel = `RST_OSC_SEL;
          d.cfg.xen_lo = `RST_XEN_LO;
          d.cfg.xen_hi = `RST_XEN_HI;
          d.cfg.mul_sel = `RST_MUL_SEL;
          d.cfg.mul_on = `RST_MUL_ON;
          if (q.was_gated) begin
            d.periph_rst = 1'b1; // RQ7
            d.prst_cnt = 4'h0;
            d.mode = ST_PRST;
          end else begin
            d.mode = ST_NORMAL;
          end
        end
      end
      ST_PRST: begin
        // only the cut-off domain is reset; config here stays powered
        if (q.prst_cnt == 4'(`PERIPH_RST_CYC - 1)) begin
          d.periph_rst = 1'b0; // RQ7
          d.vec_reset = 1'b1; // RQ8
          d.mode = ST_NORMAL;
        end else begin
          d.prst_cnt = q.prst_cnt + 4'h1;
        end
      end
      default: d.mode = ST_NORMAL;
    endcase
  end

  // reset exit lands in normal directly, without warm-up
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0; // RQ5 RQ20
      q.mode <= ST_NORMAL;
      q.cfg.standby_mode_field <= `RST_STANDBY_MODE_FIELD;
      q.cfg.warmup_time_value <= `RST_WARMUP_TIME_VALUE;
      q.cfg.clock_divider_a <= `RST_CLOCK_DIVIDER_A;
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign s_axi_awready_o = aw_fire;
  assign s_axi_wready_o = w_fire;
  assign s_axi_bvalid_o = q.bus.bvalid;
  assign s_axi_bresp_o = q.bus.bresp;
  assign s_axi_arready_o = ar_fire;
  assign s_axi_rvalid_o = q.bus.rvalid;
  assign s_axi_rdata_o = q.bus.rdata;
  assign s_axi_rresp_o = q.bus.rresp;
  assign sysclk_en_o = q.sysclk_en;
  assign osc_on_o = q.osc_on;
  assign periph_rst_o = q.periph_rst;
  assign core_run_o = q.core_run;
  assign vec_reset_o = q.vec_reset;
  assign port_state_hold_o = q.cfg.hold;
  assign warmup_time_value_o = q.cfg.warmup_time_value;
  assign warmup_source_select_hi_o = q.cfg.wsel_hi;
  assign warmup_source_select_lo_o = q.cfg.wsel_lo;
  assign system_osc_select_o = q.cfg.osc_sel;
  assign ext_low_osc_enable_o = q.cfg.xen_lo;
  assign ext_high_osc_enable_o = q.cfg.xen_hi;
  assign multiplier_clock_select_o = q.cfg.mul_sel;
  assign multiplier_power_on_o = q.cfg.mul_on;
  assign clock_divider_a_o = q.cfg.clock_divider_a;

endmodule

`default_nettype wire

// ==== tb/wakeup_seq_sva.sv ====
/*
  Port checker of the wake-up warm-up sequencer.
  Assumes it is bound onto wakeup_seq; one clock, one reset.
*/
`timescale 1ns/1ps
`default_nettype none

module wakeup_seq_sva (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic wake_req_i,
  input wire logic sysclk_en_o,
  input wire logic osc_on_o,
  input wire logic periph_rst_o,
  input wire logic core_run_o,
  input wire logic vec_reset_o,
  input wire logic [11:0] warmup_time_value_o,
  input wire logic system_osc_select_o,
  input wire logic multiplier_power_on_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic seen_q;
  logic stop_q;
  logic [12:0] wcnt_q;

  // ****
  // stop tracking: the reset release also raises osc and clock, keep it out
  // ****
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen_q <= 1'b0;
      stop_q <= 1'b0;
      wcnt_q <= 13'h0000;
    end else begin
      seen_q <= seen_q | osc_on_o;
      if (seen_q && !osc_on_o) begin
        stop_q <= 1'b1;
      end else if (sysclk_en_o) begin
        stop_q <= 1'b0;
      end
      if (!stop_q || !osc_on_o) begin
        wcnt_q <= 13'h0000;
      end else if (!sysclk_en_o) begin
        wcnt_q <= wcnt_q + 13'h0001;
      end
    end
  end

  a_warm_length: assert property (
    $rose(sysclk_en_o) && stop_q |-> wcnt_q >= {1'b0, warmup_time_value_o} + 13'h0001
      && wcnt_q <= {1'b0, warmup_time_value_o} + 13'h0002)
    else $error("clock released off the warm-up count");
  a_sel_cleared: assert property (
    $rose(sysclk_en_o) && stop_q |-> !system_osc_select_o && !multiplier_power_on_o)
    else $error("select bits kept after stop exit");
  a_osc_first: assert property ($rose(osc_on_o) && seen_q |-> !sysclk_en_o)
    else $error("clock released with oscillator start");
  a_wake_starts: assert property (
    (stop_q && !osc_on_o && wake_req_i) [*4] |-> ##[0:2] osc_on_o)
    else $error("oscillator not started on wake");
  a_no_warm_reset: assert property (
    $fell(rst_i) |=> sysclk_en_o && osc_on_o && core_run_o)
    else $error("warm-up run after reset");
  a_periph_len: assert property (
    $rose(periph_rst_o) |-> periph_rst_o [*5] ##1 !periph_rst_o)
    else $error("peripheral reset length wrong");
  a_vec_follows: assert property ($fell(periph_rst_o) |-> ##[0:2] vec_reset_o)
    else $error("no reset vector after gated wake");
  a_vec_pulse: assert property (vec_reset_o |=> !vec_reset_o)
    else $error("reset vector longer than a cycle");
  a_core_gated: assert property (!sysclk_en_o |-> !core_run_o)
    else $error("core runs without clock");
  a_pending_stays: assert property (
    (wake_req_i && core_run_o) [*4] |=> core_run_o)
    else $error("mode entered with wake pending");
endmodule

bind wakeup_seq wakeup_seq_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wake_req_i(wake_req_i),
  .sysclk_en_o(sysclk_en_o), .osc_on_o(osc_on_o), .periph_rst_o(periph_rst_o),
  .core_run_o(core_run_o), .vec_reset_o(vec_reset_o),
  .warmup_time_value_o(warmup_time_value_o), .system_osc_select_o(system_osc_select_o),
  .multiplier_power_on_o(multiplier_power_on_o)
);
`default_nettype wire

// ==== tb/wake_source_model.sv ====
/*
  Wake source beside the core: one level wake request after a delay.
  Assumes the bench pulses fire_i for one cycle while busy_o is low.
*/
`timescale 1ns/1ps
`default_nettype none

module wake_source_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bench control
  input wire logic fire_i,
  input wire logic [11:0] delay_i,
  input wire logic [15:0] hold_i,
  // wake level and state
  output logic wake_o,
  output logic busy_o
);
  int cnt;

  // only a maskable level source: no watchdog or detector wake here
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      wake_o <= 1'b0;
      cnt <= 0;
    end else if (!busy_o) begin
      busy_o <= fire_i;
      cnt <= delay_i;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end else if (!wake_o) begin
      wake_o <= 1'b1;
      cnt <= hold_i;
    end else begin
      wake_o <= 1'b0;
      busy_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== tb/wakeup_seq_tb.sv ====
/*
  Self-checking bench of the wake-up sequencer: bus tasks, mode table, abort, reset.
  Assumes the checker is bound in and the map header is on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_seq_map.svh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", nm, e, a); end end

module wakeup_seq_tb;
  logic clk_i = 0, rst_i = 1, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, fire = 0;
  logic [11:0] aw_a = 0, ar_a = 0, dly = 0, warmup_time_value, t;
  logic [31:0] w_d = 0, r_d, d;
  logic [3:0] w_s = 4'hF;
  logic [1:0] b_resp, r_resp, r, m;
  logic aw_r, w_r, b_v, ar_r, r_v, sysclk, osc, prst, run, vec, hold, wake, mbusy;
  logic wsh, wsl, osel, xl, xh, msel, mon, prst_seen, vec_seen;
  logic [2:0] clock_divider_a, mode;
  logic [4:0] s;
  logic [15:0] hld = 16'd20;
  int fails = 0, n_checks = 0;

  wakeup_seq dut (.clk_i(clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_r),
    .s_axi_wdata_i(w_d), .s_axi_wstrb_i(w_s), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_r),
    .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
    .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_r),
    .s_axi_rdata_o(r_d), .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r),
    .wake_req_i(wake), .sysclk_en_o(sysclk), .osc_on_o(osc), .periph_rst_o(prst),
    .core_run_o(run), .vec_reset_o(vec), .port_state_hold_o(hold),
    .warmup_time_value_o(warmup_time_value), .warmup_source_select_hi_o(wsh),
    .warmup_source_select_lo_o(wsl), .system_osc_select_o(osel), .ext_low_osc_enable_o(xl),
    .ext_high_osc_enable_o(xh), .multiplier_clock_select_o(msel),
    .multiplier_power_on_o(mon), .clock_divider_a_o(clock_divider_a));
  wake_source_model u_src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
    .delay_i(dly), .hold_i(hld), .wake_o(wake), .busy_o(mbusy));

  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (prst) prst_seen <= 1'b1;
    if (vec) vec_seen <= 1'b1;
  end

  // ****
  // bus and wait tasks
  // ****
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick(inout int n);
    @(posedge clk_i);
    n++;
    if (n > 40000) begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dd, input logic [1:0] er);
    int n;
    logic ta, tw;
    n = 0;
    ta = 0;
    tw = 0;
    @(posedge clk_i);
    aw_a <= a;
    w_d <= dd;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    while (!(ta && tw)) begin
      tick(n);
      if (aw_r && !ta) begin
        ta = 1;
        aw_v <= 1'b0;
      end
      if (w_r && !tw) begin
        tw = 1;
        w_v <= 1'b0;
      end
    end
    while (!b_v) tick(n);
    `CHK("bresp", er, b_resp)
    b_r <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] dd, output logic [1:0] rr);
    int n;
    n = 0;
    @(posedge clk_i);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do tick(n); while (!ar_r);
    ar_v <= 1'b0;
    do tick(n); while (!r_v);
    dd = r_d;
    rr = r_resp;
    r_r <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    rd(a, d, r);
    `CHK("rresp", er, r)
    if (er == 2'h0) `CHK("rdata", e, d)
  endtask
  function automatic logic [31:0] osc_word(input logic [11:0] tt, input logic [4:0] ss);
    osc_word = {tt, 4'h0, ss[4], ss[3], 5'h00, ss[2], 6'h00, ss[1], ss[0]};
  endfunction

  // ****
  // main sequence
  // ****
  initial begin
    int n;
    void'($urandom(26888));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(`OFF_STANDBY_MODE_FIELD_CTRL, {29'h0, `RST_STANDBY_MODE_FIELD}, 2'h0);
    rchk(`OFF_OSC_CTRL, 32'h0, 2'h0);
    rchk(12'h100, 32'h0, 2'h2);
    wr(`OFF_STATUS, 32'h0, 2'h2);
    wr(`OFF_STANDBY_MODE_FIELD_CTRL, 32'h2, 2'h0);
    rchk(`OFF_STANDBY_MODE_FIELD_CTRL, {29'h0, `RST_STANDBY_MODE_FIELD}, 2'h0);
    $display("test map done");
    for (int i = 0; i < 3; i++) begin
      mode = i == 0 ? `STANDBY_MODE_FIELD_DEEP : i == 1 ? `STANDBY_MODE_FIELD_IDLE : `STANDBY_MODE_FIELD_GATED;
      t = i == 0 ? 12'h096 : 12'($urandom());
      s = i == 2 ? 5'h00 : {{3{1'($urandom())}}, 2'($urandom())};
      m = i == 2 ? 2'h0 : 2'($urandom());
      wr(`OFF_OSC_CTRL, osc_word(t, s), 2'h0);
      wr(`OFF_MULT_SEL, {30'h0, m}, 2'h0);
      wr(`OFF_SYS_CTRL, {29'h0, i == 2 ? 3'h0 : 3'($urandom())}, 2'h0);
      wr(`OFF_STANDBY_MODE_FIELD_CTRL, {15'h0, i == 2, 13'h0, mode}, 2'h0);
      prst_seen <= 1'b0;
      vec_seen <= 1'b0;
      wr(`OFF_WAKE_CMD, 32'h1, 2'h0);
      n = 0;
      while (run) tick(n);
      `CHK("osc_on", i == 1, osc)
      dly <= i == 2 ? 12'd2250 : 12'($urandom_range(40));
      hld <= i == 2 ? 16'd25000 : 16'd20;
      fire <= 1'b1;
      @(posedge clk_i);
      fire <= 1'b0;
      while (!run) tick(n);
      while (i == 2 && !vec_seen) tick(n);
      `CHK("sysclk", 1'b1, sysclk)
      `CHK("warmup", t, warmup_time_value)
      `CHK("periph_rst", i == 2, prst_seen)
      rchk(`OFF_OSC_CTRL, osc_word(t, i == 1 ? s : 5'h00), 2'h0);
      rchk(`OFF_MULT_SEL, {30'h0, i == 1 ? m : 2'h0}, 2'h0);
      if (i == 2) `CHK("hold", 1'b1, hold)
      while (mbusy) tick(n);
      $display("test mode %0d done", i);
    end
    s = 5'h1D;
    wr(`OFF_OSC_CTRL, osc_word(t, s), 2'h0);
    dly <= 12'd0;
    hld <= 16'd20;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    n = 0;
    while (!wake) tick(n);
    repeat (3) @(posedge clk_i);
    wr(`OFF_WAKE_CMD, 32'h1, 2'h0);
    repeat (8) @(posedge clk_i);
    `CHK("core_run", 1'b1, run)
    rchk(`OFF_OSC_CTRL, osc_word(t, s), 2'h0);
    rd(`OFF_STATUS, d, r);
    `CHK("aborted", 1'b1, d[7])
    while (mbusy) tick(n);
    $display("test abort done");
    wr(`OFF_STANDBY_MODE_FIELD_CTRL, {29'h0, `STANDBY_MODE_FIELD_DEEP}, 2'h0);
    wr(`OFF_WAKE_CMD, 32'h1, 2'h0);
    while (run) tick(n);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK("sysclk", 1'b1, sysclk)
    rchk(`OFF_OSC_CTRL, 32'h0, 2'h0);
    $display("test reset exit done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
